// *** common/eisp_params.svh ***
// constants of the engine ic spi status port: offsets, fields, resets, counts
`ifndef EISP_PARAMS_SVH
`define EISP_PARAMS_SVH

// ****************************************************************
// frame layout
// ****************************************************************
`define EISP_FRAME_BITS     5'h10
`define EISP_CNT_SAT        5'h1f
`define EISP_CMD_MSB        15
`define EISP_CMD_LSB        12
`define EISP_ADDR_MSB       11
`define EISP_ADDR_LSB       8
`define EISP_DATA_MSB       7
`define EISP_DATA_LSB       0
`define EISP_CHECK_PREFIX   4'h7
`define EISP_RESP_RESET     16'h0000

// ****************************************************************
// register offsets
// ****************************************************************
`define EISP_ADDR_STATUS    4'hb
`define EISP_ADDR_CRANK     4'hd
`define EISP_ADDR_ERROR     4'he
`define EISP_ADDR_ID        4'hf

// ****************************************************************
// field positions, masks and reset values
// ****************************************************************
`define EISP_THR_MSB        7
`define EISP_THR_LSB        4
`define EISP_BLK_MSB        3
`define EISP_BLK_LSB        0
`define EISP_PEAK_MSB       7
`define EISP_PEAK_LSB       4
`define EISP_CLAMP_POS_BIT  2
`define EISP_CLAMP_NEG_BIT  1
`define EISP_OT_BIT         0
`define EISP_ERR_BIT        0
`define EISP_STATUS_MASK    8'hf7
`define EISP_ERROR_MASK     8'h01
`define EISP_CRANK_RESET    8'h00
`define EISP_STATUS_RESET   8'h00
`define EISP_ERROR_RESET    8'h00
// model and revision codes: values are arbitrary
`define EISP_ID_MODEL       3'h5
`define EISP_ID_REV         5'h01
`define EISP_ID_RESET       {`EISP_ID_MODEL, `EISP_ID_REV}

`endif

// *** common/eisp_pkg.sv ***
// types of the engine ic spi status port
package eisp_pkg;

	// ****************************************************************
	// frame sequencer states
	// ****************************************************************
	typedef enum logic [1:0] {
		EISP_ST_IDLE  = 2'b00,
		EISP_ST_FRAME = 2'b01,
		EISP_ST_EXEC  = 2'b10,
		EISP_ST_RESP  = 2'b11
	} eisp_state_type;

	// ****************************************************************
	// command codes in bits 15..12
	// ****************************************************************
	typedef enum logic [3:0] {
		EISP_CMD_CHECK   = 4'h0,
		EISP_CMD_RD_CFG  = 4'h1,
		EISP_CMD_WR_CFG  = 4'h2,
		EISP_CMD_RD_STAT = 4'h3,
		EISP_CMD_WR_STAT = 4'h4
	} eisp_cmd_type;

endpackage

// *** rtl/eisp_spi_port.sv ***
// spi slave port with crank, sensor status, error and id registers
// ****************************************************************
// ****************************************************************
`timescale 1ns/1ps
`include "eisp_params.svh"
module eisp_spi_port
	import eisp_pkg::*;
(
	// clock and reset
	input  wire logic       I_CLK,
	input  wire logic       I_RST_N,
	// spi pins
	input  wire logic       I_SCLK,
	input  wire logic       I_SI,
	input  wire logic       I_SPI_SELECT_N,
	output logic            O_SO,
	output logic            O_SO_OE_N,
	// sensor conditioner and k-line status pins
	input  wire logic [3:0] I_SENSOR_PEAK_CODE,
	input  wire logic       I_SENSOR_PEAK_STB,
	input  wire logic       I_SENSOR_POS_INPUT_CLAMP,
	input  wire logic       I_SENSOR_NEG_INPUT_CLAMP,
	input  wire logic       I_KLINE_OVERTEMP_FLAG,
	// self test control
	input  wire logic       I_SELF_TEST_WRITE_ENABLE,
	// register driven outputs
	output logic [3:0]      O_THRESHOLD_SEL,
	output logic [3:0]      O_BLANKING_SEL,
	output logic            O_SPI_ERROR
);

	// ****************************************************************
	// input synchronisation
	// ****************************************************************
	logic [11:0]    sync_d;
	logic [11:0]    sync_q;
	logic           sclk_s;
	logic           si_s;
	logic           sel_n_s;
	logic           sel_s;
	logic           peak_stb_s;
	logic           pos_clamp_s;
	logic           neg_clamp_s;
	logic           ot_s;
	logic           stwe_s;
	logic [3:0]     peak_code_s;

	// all pins pass two flops; select enters inverted so reset reads deselected
	assign sync_d = {I_SCLK, I_SI, ~I_SPI_SELECT_N, I_SENSOR_PEAK_STB,
	                 I_SENSOR_POS_INPUT_CLAMP, I_SENSOR_NEG_INPUT_CLAMP,
	                 I_KLINE_OVERTEMP_FLAG, I_SELF_TEST_WRITE_ENABLE,
	                 I_SENSOR_PEAK_CODE};

	eisp_sync #(
		.W     (12)
	) u_sync (
		.clk   (I_CLK),
		.rst_n (I_RST_N),
		.d     (sync_d),
		.q     (sync_q)
	);

	// same latency on every bit keeps si aligned with the clock edge
	assign {sclk_s, si_s, sel_s, peak_stb_s, pos_clamp_s, neg_clamp_s,
	        ot_s, stwe_s, peak_code_s} = sync_q;
	assign sel_n_s = ~sel_s;

	// ****************************************************************
	// edge detection
	// ****************************************************************
	logic           sclk_d_r;
	logic           sclk_d_nxt;
	logic           stb_d_r;
	logic           stb_d_nxt;
	logic           sclk_rise;
	logic           sclk_fall;
	logic           peak_load;

	// delayed copies of the synchronised levels
	always_comb begin
		sclk_d_nxt = sclk_s;
		stb_d_nxt  = peak_stb_s;
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			sclk_d_r <= 1'b0;
			stb_d_r  <= 1'b0;
		end else begin
			sclk_d_r <= sclk_d_nxt;
			stb_d_r  <= stb_d_nxt;
		end
	end

	assign sclk_rise = sclk_s & ~sclk_d_r;
	assign sclk_fall = ~sclk_s & sclk_d_r;
	// code must be steady while the strobe is high
	assign peak_load = peak_stb_s & ~stb_d_r;

	// ****************************************************************
	// frame sequencer and shift registers
	// ****************************************************************
	eisp_state_type state_r;
	eisp_state_type state_nxt;
	logic [4:0]     cnt_r;
	logic [4:0]     cnt_nxt;
	logic [15:0]    rx_r;
	logic [15:0]    rx_nxt;
	logic [15:0]    tx_r;
	logic [15:0]    tx_nxt;
	logic           oe_n_r;
	logic           oe_n_nxt;
	logic [15:0]    resp_r;

	// select level drives framing; clock edges only count inside a frame
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		rx_nxt    = rx_r;
		tx_nxt    = tx_r;
		oe_n_nxt  = oe_n_r;
		unique case (state_r)
			EISP_ST_IDLE: begin
				if (!sel_n_s) begin
					state_nxt = EISP_ST_FRAME;
					cnt_nxt   = 5'h00;
					tx_nxt    = resp_r;
					oe_n_nxt  = 1'b0;
				end
			end
			EISP_ST_FRAME: begin
				if (sel_n_s) begin
					state_nxt = EISP_ST_EXEC;
					oe_n_nxt  = 1'b1;
				end else begin
					if (sclk_rise) begin
						rx_nxt = {rx_r[14:0], si_s};
						// saturate so long frames never wrap back to sixteen
						cnt_nxt = cnt_r + {4'h0, cnt_r != `EISP_CNT_SAT};
					end
					if (sclk_fall && cnt_r != 5'h00) begin
						tx_nxt = {tx_r[14:0], 1'b0};
					end
				end
			end
			EISP_ST_EXEC: state_nxt = EISP_ST_RESP;
			EISP_ST_RESP: state_nxt = EISP_ST_IDLE;
		endcase
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state_r <= EISP_ST_IDLE;
			cnt_r   <= 5'h00;
			rx_r    <= 16'h0000;
			tx_r    <= 16'h0000;
			oe_n_r  <= 1'b1;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			rx_r    <= rx_nxt;
			tx_r    <= tx_nxt;
			oe_n_r  <= oe_n_nxt;
		end
	end

	// ****************************************************************
	// command decode
	// ****************************************************************
	logic [3:0]     cmd;
	logic [3:0]     addr;
	logic [7:0]     wdata;
	logic           frame_ok;
	logic           cmd_ok;

	assign cmd   = rx_r[`EISP_CMD_MSB:`EISP_CMD_LSB];
	assign addr  = rx_r[`EISP_ADDR_MSB:`EISP_ADDR_LSB];
	assign wdata = rx_r[`EISP_DATA_MSB:`EISP_DATA_LSB];
	assign frame_ok = (cnt_r == `EISP_FRAME_BITS);

	// status-type offsets, shared by the read and write checks
	function automatic logic is_stat_addr(input logic [3:0] a);
		is_stat_addr = (a == `EISP_ADDR_STATUS) || (a == `EISP_ADDR_ERROR) ||
		               (a == `EISP_ADDR_ID);
	endfunction

	// host write to a status register: clear-only outside self test
	function automatic logic [7:0] wr_status(input logic [7:0] old_v, data_v, mask_v,
	                                         input logic stwe_v);
		wr_status = stwe_v ? (data_v & mask_v) : (old_v & data_v & mask_v);
	endfunction

	// unknown commands and unmapped offsets are message errors
	always_comb begin
		unique case (cmd)
			EISP_CMD_CHECK:   cmd_ok = 1'b1;
			EISP_CMD_RD_CFG:  cmd_ok = (addr == `EISP_ADDR_CRANK);
			EISP_CMD_WR_CFG:  cmd_ok = (addr == `EISP_ADDR_CRANK);
			EISP_CMD_RD_STAT: cmd_ok = is_stat_addr(addr);
			EISP_CMD_WR_STAT: cmd_ok = is_stat_addr(addr);
			default:          cmd_ok = 1'b0;
		endcase
	end

	// ****************************************************************
	// registers and pending response
	// ****************************************************************
	logic [7:0]     crank_r;
	logic [7:0]     crank_nxt;
	logic [7:0]     status_r;
	logic [7:0]     status_nxt;
	logic [7:0]     err_r;
	logic [7:0]     err_nxt;
	logic [7:0]     id_r;
	logic [7:0]     id_nxt;
	logic [7:0]     rd_data_r;
	logic [7:0]     rd_data_nxt;
	logic [15:0]    resp_nxt;
	logic           rd_pend_r;
	logic           rd_pend_nxt;
	logic           err_set;

	// execute once per frame, then fold in hardware events so a set wins
	always_comb begin
		crank_nxt   = crank_r;
		status_nxt  = status_r;
		err_nxt     = err_r;
		id_nxt      = id_r;
		rd_data_nxt = rd_data_r;
		resp_nxt    = resp_r;
		rd_pend_nxt = 1'b0;
		err_set     = 1'b0;
		if (state_r == EISP_ST_EXEC) begin
			if (!frame_ok || !cmd_ok) begin
				err_set = 1'b1;
			end else begin
				unique case (cmd)
					EISP_CMD_CHECK: resp_nxt = {`EISP_CHECK_PREFIX, rx_r[11:0]};
					EISP_CMD_RD_CFG, EISP_CMD_RD_STAT: begin
						rd_pend_nxt = 1'b1;
						unique case (addr)
							`EISP_ADDR_CRANK:  rd_data_nxt = crank_r;
							`EISP_ADDR_STATUS: rd_data_nxt = status_r;
							`EISP_ADDR_ERROR:  rd_data_nxt = err_r;
							`EISP_ADDR_ID:     rd_data_nxt = id_r;
							default:           rd_data_nxt = 8'h00;
						endcase
					end
					EISP_CMD_WR_CFG: begin
						crank_nxt = wdata;
						resp_nxt  = rx_r;
					end
					EISP_CMD_WR_STAT: begin
						resp_nxt = rx_r;
						if (addr == `EISP_ADDR_STATUS) begin
							status_nxt = wr_status(status_r, wdata, `EISP_STATUS_MASK, stwe_s);
						end
						if (addr == `EISP_ADDR_ERROR) begin
							err_nxt = wr_status(err_r, wdata, `EISP_ERROR_MASK, stwe_s);
						end
						// read-only outside self test; ignored, not an error
						if (addr == `EISP_ADDR_ID && stwe_s) begin
							id_nxt = wdata;
						end
					end
					default: resp_nxt = resp_r;
				endcase
			end
		end
		// read data waits one cycle in its register, then becomes the reply
		if (state_r == EISP_ST_RESP && rd_pend_r) begin
			resp_nxt = {rx_r[15:8], rd_data_r};
		end
		// faults stop updating while self test owns the status register
		if (!stwe_s) begin
			if (peak_load) begin
				status_nxt[`EISP_PEAK_MSB:`EISP_PEAK_LSB] = peak_code_s;
			end
			status_nxt[`EISP_CLAMP_POS_BIT] |= pos_clamp_s;
			status_nxt[`EISP_CLAMP_NEG_BIT] |= neg_clamp_s;
			status_nxt[`EISP_OT_BIT]        |= ot_s;
		end
		if (err_set) begin
			err_nxt[`EISP_ERR_BIT] = 1'b1;
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			crank_r   <= `EISP_CRANK_RESET;
			status_r  <= `EISP_STATUS_RESET;
			err_r     <= `EISP_ERROR_RESET;
			id_r      <= `EISP_ID_RESET;
			rd_data_r <= 8'h00;
			resp_r    <= `EISP_RESP_RESET;
			rd_pend_r <= 1'b0;
		end else begin
			crank_r   <= crank_nxt;
			status_r  <= status_nxt;
			err_r     <= err_nxt;
			id_r      <= id_nxt;
			rd_data_r <= rd_data_nxt;
			resp_r    <= resp_nxt;
			rd_pend_r <= rd_pend_nxt;
		end
	end

	// ****************************************************************
	// outputs, all straight from flops
	// ****************************************************************
	assign O_SO            = tx_r[15];
	assign O_SO_OE_N       = oe_n_r;
	assign O_THRESHOLD_SEL = crank_r[`EISP_THR_MSB:`EISP_THR_LSB];
	assign O_BLANKING_SEL  = crank_r[`EISP_BLK_MSB:`EISP_BLK_LSB];
	assign O_SPI_ERROR     = err_r[`EISP_ERR_BIT];

endmodule

// *** rtl/eisp_sync.sv ***
// two flip-flop synchroniser for a bundle of asynchronous inputs
`timescale 1ns/1ps
module eisp_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_r;

	// first stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule

// *** verif/eisp_spi_checker.sv ***
// concurrent checks on the pins of the spi status port
`timescale 1ns/1ps
`include "eisp_params.svh"
module eisp_spi_checker (
	// clock and reset
	input wire logic       I_CLK,
	input wire logic       I_RST_N,
	// spi pins
	input wire logic       I_SCLK,
	input wire logic       I_SI,
	input wire logic       I_SPI_SELECT_N,
	input wire logic       O_SO,
	input wire logic       O_SO_OE_N,
	// status pins
	input wire logic [3:0] I_SENSOR_PEAK_CODE,
	input wire logic       I_SENSOR_PEAK_STB,
	input wire logic       I_SENSOR_POS_INPUT_CLAMP,
	input wire logic       I_SENSOR_NEG_INPUT_CLAMP,
	input wire logic       I_KLINE_OVERTEMP_FLAG,
	input wire logic       I_SELF_TEST_WRITE_ENABLE,
	// register outputs
	input wire logic [3:0] O_THRESHOLD_SEL,
	input wire logic [3:0] O_BLANKING_SEL,
	input wire logic       O_SPI_ERROR
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);

	// ****************************************************************
	// output driver and shifting
	// ****************************************************************
	// pins pass two flops, so every figure allows the sync delay
	sel_idle_off_a: assert property (I_SPI_SELECT_N [*6] |-> O_SO_OE_N)
		else $error("output driven while deselected");
	oe_on_fall_a: assert property ($fell(I_SPI_SELECT_N) |-> O_SO_OE_N ##[1:3] !O_SO_OE_N)
		else $error("output not enabled after select fall");
	oe_off_rise_a: assert property ($rose(I_SPI_SELECT_N) |-> !O_SO_OE_N ##[1:4] O_SO_OE_N)
		else $error("output not released after select rise");
	so_hold_a: assert property ($rose(I_SCLK) |-> ##1 $stable(O_SO) [*3])
		else $error("serial output moved while clock high");

	// ****************************************************************
	// register side effects
	// ****************************************************************
	err_change_a: assert property ($changed(O_SPI_ERROR) |-> $past(I_SPI_SELECT_N, 3))
		else $error("error bit moved inside a frame");
	crank_change_a: assert property (!$stable({O_THRESHOLD_SEL, O_BLANKING_SEL})
		|-> $past(I_SPI_SELECT_N, 3) && I_SPI_SELECT_N)
		else $error("crank outputs moved inside a frame");
	crank_on_err_a: assert property ($rose(O_SPI_ERROR)
		|-> $stable({O_THRESHOLD_SEL, O_BLANKING_SEL}) ##1 $stable(O_THRESHOLD_SEL))
		else $error("rejected frame changed crank outputs");
	reset_vals_a: assert property ($rose(I_RST_N) |-> O_SO_OE_N && !O_SPI_ERROR
		&& {O_THRESHOLD_SEL, O_BLANKING_SEL} == `EISP_CRANK_RESET)
		else $error("wrong values after reset");

	// main scenarios reached
	err_set_c: cover property ($rose(O_SPI_ERROR));
	err_clr_c: cover property ($fell(O_SPI_ERROR));
	crank_wr_c: cover property ($changed(O_THRESHOLD_SEL));
endmodule

// *** verif/eisp_spi_master.sv ***
// host side spi master model: frames of any pulse count
`timescale 1ns/1ps
module eisp_spi_master (
	// clock
	input  wire logic i_clk,
	// spi pins
	input  wire logic i_so,
	output logic      o_sclk,
	output logic      o_si,
	output logic      o_sel_n
);
	initial begin
		o_sclk = 1'b0;
		o_si = 1'b0;
		o_sel_n = 1'b1;
	end

	// ****************************************************************
	// one frame; quiet keeps select high so the port must ignore it
	// ****************************************************************
	// 8 clocks per serial period: 320 ns, half high half low
	task automatic frame(input logic [15:0] w, input int n, input bit quiet,
		output logic [15:0] rx);
		rx = 16'h0000;
		@(posedge i_clk);
		o_sel_n <= quiet;
		repeat (6) @(posedge i_clk);
		for (int i = 0; i < n; i++) begin
			o_si <= w[15 - (i % 16)];
			repeat (4) @(posedge i_clk);
			rx = {rx[14:0], i_so};
			o_sclk <= 1'b1;
			repeat (4) @(posedge i_clk);
			o_sclk <= 1'b0;
		end
		repeat (4) @(posedge i_clk);
		o_sel_n <= 1'b1;
		o_si <= ~o_si;
		repeat (12) @(posedge i_clk);
	endtask
endmodule

// *** verif/tb.sv ***
// self-checking bench of the spi status port
`timescale 1ns/1ps
`include "eisp_params.svh"
module tb;
	import eisp_pkg::*;
	logic        clk, rst_n, sclk, si, sel_n, so, so_oe_n, so_w;
	logic        so_last = 1'b0;
	logic [3:0]  peak, thr, blk;
	logic        stb, cpos, cneg, ot, stwe, err;
	logic [15:0] exp_r, d, r, s;
	int          n_fail, total_checks, cyc;
	int          seed = 32'h94e24eda;

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// released line shows the inverse of its last bit
	always @(posedge clk) if (!so_oe_n) so_last <= so;
	assign so_w = so_oe_n ? ~so_last : so;

	eisp_spi_master u_eisp_spi_master (.i_clk(clk), .i_so(so_w), .o_sclk(sclk), .o_si(si),
		.o_sel_n(sel_n));
	eisp_spi_port u_eisp_spi_port (.I_CLK(clk), .I_RST_N(rst_n), .I_SCLK(sclk), .I_SI(si),
		.I_SPI_SELECT_N(sel_n), .O_SO(so), .O_SO_OE_N(so_oe_n), .I_SENSOR_PEAK_CODE(peak),
		.I_SENSOR_PEAK_STB(stb), .I_SENSOR_POS_INPUT_CLAMP(cpos),
		.I_SENSOR_NEG_INPUT_CLAMP(cneg), .I_KLINE_OVERTEMP_FLAG(ot),
		.I_SELF_TEST_WRITE_ENABLE(stwe), .O_THRESHOLD_SEL(thr), .O_BLANKING_SEL(blk),
		.O_SPI_ERROR(err));

	// ****************************************************************
	// helpers
	// ****************************************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		total_checks++;
		if (seen !== want) begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, want);
		end
	endtask
	// response of the previous frame checked, then next one noted
	task automatic tr(input logic [15:0] w, input int n, input int quiet, input logic [15:0] nxt);
		logic [15:0] rx;
		u_eisp_spi_master.frame(w, n, quiet != 0, rx);
		if (n == 16 && !quiet) check(rx, exp_r);
		exp_r = nxt;
	endtask
	function automatic logic [7:0] st(input logic [3:0] p, input logic c1, c2, c3);
		return {p, 1'b0, c1, c2, c3};
	endfunction
	task automatic summarize();
		if (n_fail == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// hang guard, about three times the expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			summarize();
		end
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		{rst_n, peak, stb, cpos, cneg, ot, stwe} <= '0;
		exp_r = `EISP_RESP_RESET;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		check({8'h00, thr, blk}, {8'h00, `EISP_CRANK_RESET});
		check({15'h0, err}, 16'h0000);
		d = 16'($random(seed));
		tr({4'h0, d[11:0]}, 16, 0, {4'h7, d[11:0]});
		tr({8'h2d, d[7:0]}, 16, 0, {8'h2d, d[7:0]});
		check({8'h00, thr, blk}, {8'h00, d[7:0]});
		tr(16'h1d00, 16, 0, {8'h1d, d[7:0]});
		tr(16'h4f00, 16, 0, 16'h4f00);
		tr(16'h3f00, 16, 0, {8'h3f, `EISP_ID_RESET});
		// sensor and k-line events raise their status bits
		s = 16'($random(seed));
		r = 16'($random(seed));
		peak <= s[3:0];
		{stb, cpos, cneg, ot} <= 4'hf;
		repeat (4) @(posedge clk);
		{stb, cpos, cneg, ot} <= 4'h0;
		repeat (4) @(posedge clk);
		tr(16'h3b00, 16, 0, {8'h3b, st(s[3:0], 1'b1, 1'b1, 1'b1)});
		tr({8'h4b, r[7:0]}, 16, 0, {8'h4b, r[7:0]});
		tr(16'h3b00, 16, 0, {8'h3b, st(s[3:0], 1'b1, 1'b1, 1'b1) & r[7:0] & 8'hf7});
		stwe <= 1'b1;
		tr({8'h4b, r[15:8]}, 16, 0, {8'h4b, r[15:8]});
		tr(16'h3b00, 16, 0, {8'h3b, r[15:8] & `EISP_STATUS_MASK});
		tr({8'h4f, r[7:0]}, 16, 0, {8'h4f, r[7:0]});
		tr(16'h3f00, 16, 0, {8'h3f, r[7:0]});
		stwe <= 1'b0;
		// clocks with select high are ignored
		tr({8'h2d, ~d[7:0]}, 16, 1, exp_r);
		check({thr, blk, 7'h0, err}, {d[7:0], 8'h00});
		// wrong pulse counts and invalid words are rejected
		for (int k = 0; k < 15; k++) begin
			if (k < 2)
				tr({8'h2d, ~d[7:0]}, 15 + 2 * k, 0, exp_r);
			else if (k < 13)
				tr({k[3:0] + 4'h3, 4'hd, ~d[7:0]}, 16, 0, exp_r);
			else
				tr({(k == 13) ? 8'h4d : 8'h2b, ~d[7:0]}, 16, 0, exp_r);
			check({8'h00, thr, blk}, {8'h00, d[7:0]});
			check({15'h0, err}, 16'h0001);
			tr(16'h4e00, 16, 0, 16'h4e00);
			check({15'h0, err}, 16'h0000);
		end
		tr(16'h1300, 16, 0, exp_r);
		check({15'h0, err}, 16'h0001);
		tr(16'h3e00, 16, 0, 16'h3e01);
		tr(16'h0000, 16, 0, 16'h7000);
		tr(16'h0000, 16, 0, 16'h7000);
		summarize();
	end
endmodule

bind eisp_spi_port eisp_spi_checker u_eisp_spi_checker (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
	.I_SCLK(I_SCLK), .I_SI(I_SI), .I_SPI_SELECT_N(I_SPI_SELECT_N), .O_SO(O_SO),
	.O_SO_OE_N(O_SO_OE_N), .I_SENSOR_PEAK_CODE(I_SENSOR_PEAK_CODE),
	.I_SENSOR_PEAK_STB(I_SENSOR_PEAK_STB), .I_SENSOR_POS_INPUT_CLAMP(I_SENSOR_POS_INPUT_CLAMP),
	.I_SENSOR_NEG_INPUT_CLAMP(I_SENSOR_NEG_INPUT_CLAMP),
	.I_KLINE_OVERTEMP_FLAG(I_KLINE_OVERTEMP_FLAG),
	.I_SELF_TEST_WRITE_ENABLE(I_SELF_TEST_WRITE_ENABLE), .O_THRESHOLD_SEL(O_THRESHOLD_SEL),
	.O_BLANKING_SEL(O_BLANKING_SEL), .O_SPI_ERROR(O_SPI_ERROR));
